// file: hw/pib_pkg.sv
// Purpose: constants and types for the peripheral interrupt enable bank
// Assumes: APB slave, 32-bit data, one aligned word per register
// Notes: all sources and flags share one bit layout
// Behaviour
// - Enable bit 6 lets the converter-done flag raise an interrupt, else masks it.
// - Enable bit 5 lets the serial receive flag raise an interrupt, else masks it.
// - Enable bit 4 lets the serial transmit flag raise an interrupt, else masks it.
// - Enable bit 1 lets the timer-two period match raise an interrupt, else masks it.
// - One flag bit per source is kept, at the same position as its enable bit.
// - A flag is set on its event whatever its enable or the global enable hold.
// - A peripheral interrupt reaches the core only while the group enable bit 6 is set.
// - The global enable bit 7 passes enabled interrupts to core_irq when one and blocks them when zero; irq ignores it.
package pib_pkg;

	typedef struct packed {
		logic slave_port;
		logic converter_done;
		logic serial_rx;
		logic serial_tx;
		logic sync_serial;
		logic capcomp_one;
		logic period_match;
		logic timer_one_ovf;
	} pib_src_type;

	typedef struct packed {
		logic global_irq_en;
		logic peripheral_group_irq_en;
	} pib_core_type;

	typedef enum logic [0:0] {
		PIB_IDLE = 1'b0,
		PIB_DONE = 1'b1
	} pib_apb_type;

	localparam int          PIB_ADDR_W     = 8;
	localparam logic [7:0]  PIB_OFF_CORE   = 8'h08;
	localparam logic [7:0]  PIB_OFF_FLAGS  = 8'h0c;
	localparam logic [7:0]  PIB_OFF_STAT   = 8'h10;
	localparam logic [7:0]  PIB_OFF_MASK   = 8'h14;
	localparam logic [7:0]  PIB_OFF_ENABLE = 8'h8c;
	localparam logic [7:0]  PIB_RST_ENABLE = 8'h00;
	localparam logic [7:0]  PIB_RST_FLAGS  = 8'h00;
	localparam logic [7:0]  PIB_RST_STAT   = 8'h00;
	localparam logic [7:0]  PIB_RST_MASK   = 8'h00;
	localparam logic [1:0]  PIB_RST_CORE   = 2'h0;
	localparam int          PIB_POS_GIE    = 7;
	localparam int          PIB_POS_PERIPHERAL_GROUP_IRQ_EN   = 6;
	localparam logic [7:0]  PIB_OTHER_MASK = 8'h8d;

endpackage

// file: hw/pib_bank.sv
// Purpose: peripheral interrupt enable, flag and core gating bank, APB slave
// Assumes: source events are one-cycle pulses from logic on clk
// Notes: status register is a read-cleared sticky copy of the source events
`timescale 1ns/1ps
module pib_bank #(
	parameter int ADDR_W = 8
) (
	input  logic                 clk,
	input  logic                 sys_rst,
	input  logic                 ce,
	input  logic                 psel,
	input  logic                 penable,
	input  logic                 pwrite,
	input  logic [ADDR_W-1:0]    paddr,
	input  logic [31:0]          pwdata,
	output logic [31:0]          prdata,
	output logic                 pready,
	output logic                 pslverr,
	input  pib_pkg::pib_src_type src_event,
	output logic                 core_irq,
	output logic                 irq
);
	import pib_pkg::*;

	if (ADDR_W < PIB_ADDR_W) begin : g_bad_addr
		$error("pib_bank: ADDR_W too small for the register map");
	end

	pib_apb_type  state;
	pib_apb_type  next_state;
	pib_src_type  enable;
	pib_src_type  next_enable;
	pib_src_type  flags;
	pib_src_type  next_flags;
	pib_src_type  status;
	pib_src_type  next_status;
	pib_src_type  mask;
	pib_src_type  next_mask;
	pib_core_type core;
	pib_core_type next_core;
	logic [31:0]  next_prdata;
	logic         next_pready;
	logic         next_pslverr;
	logic         next_core_irq;
	logic         next_irq;
	logic [7:0]   addr;
	logic         hit;
	logic         access;
	logic         wr;
	logic         rd;
	logic [7:0]   rd_mux;

	assign addr   = paddr[7:0];
	assign access = psel && penable && (state == PIB_DONE);
	assign wr     = access && pwrite;
	assign rd     = access && !pwrite;

	// Address decode and read mux
	always_comb begin
		hit    = 1'b1;
		rd_mux = 8'h00;
		case (addr)
			PIB_OFF_ENABLE: rd_mux = enable;
			PIB_OFF_FLAGS:  rd_mux = flags;
			PIB_OFF_STAT:   rd_mux = status;
			PIB_OFF_MASK:   rd_mux = mask;
			PIB_OFF_CORE:   rd_mux = {core, 6'h00};
			default:        hit    = 1'b0;
		endcase
		if (paddr != ADDR_W'(addr)) begin
			hit = 1'b0;
		end
	end

	// APB: one wait state, answer always at the second access cycle
	always_comb begin
		next_state   = state;
		next_pready  = 1'b0;
		next_prdata  = prdata;
		next_pslverr = 1'b0;
		case (state)
			PIB_IDLE: begin
				if (psel && penable) begin
					next_state   = PIB_DONE;
					next_pready  = 1'b1;
					next_pslverr = !hit;
					next_prdata  = hit ? {24'h000000, rd_mux} : 32'h00000000;
				end
			end
			PIB_DONE: begin
				next_state = PIB_IDLE;
			end
			default: begin
				next_state = PIB_IDLE;
			end
		endcase
	end

	// Register file; events win over a same-cycle write or read clear
	always_comb begin
		next_enable = enable;
		next_flags  = flags;
		next_status = status;
		next_mask   = mask;
		next_core   = core;
		if (wr && hit) begin
			case (addr)
				PIB_OFF_ENABLE: next_enable = pwdata[7:0];
				PIB_OFF_FLAGS:  next_flags  = pwdata[7:0];
				PIB_OFF_MASK:   next_mask   = pwdata[7:0];
				PIB_OFF_CORE:   next_core   = {pwdata[PIB_POS_GIE], pwdata[PIB_POS_PERIPHERAL_GROUP_IRQ_EN]};
				default:        next_core   = core;
			endcase
		end
		if (rd && hit && addr == PIB_OFF_STAT) begin
			next_status = PIB_RST_STAT;
		end
		// Flags latch with no regard to enables
		next_flags  = next_flags | src_event;
		next_status = next_status | src_event;
	end

	// Core gating: per-source enable, then group enable, then global enable
	always_comb begin
		next_core_irq = core.global_irq_en
			&& core.peripheral_group_irq_en
			&& ((flags & enable) != 8'h00);
		next_irq = (status & mask) != 8'h00;
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state    <= PIB_IDLE;
			enable   <= PIB_RST_ENABLE;
			flags    <= PIB_RST_FLAGS;
			status   <= PIB_RST_STAT;
			mask     <= PIB_RST_MASK;
			core     <= PIB_RST_CORE;
			prdata   <= 32'h00000000;
			pready   <= 1'b0;
			pslverr  <= 1'b0;
			core_irq <= 1'b0;
			irq      <= 1'b0;
		end else if (ce) begin
			state    <= next_state;
			enable   <= next_enable;
			flags    <= next_flags;
			status   <= next_status;
			mask     <= next_mask;
			core     <= next_core;
			prdata   <= next_prdata;
			pready   <= next_pready;
			pslverr  <= next_pslverr;
			core_irq <= next_core_irq;
			irq      <= next_irq;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);

	logic gate;
	assign gate = core.global_irq_en && core.peripheral_group_irq_en;

	sequence s_setup;
		psel && !penable && ce;
	endsequence

	sequence s_access;
		psel && penable && !pready && ce;
	endsequence

	property p_apb_ack;
		s_setup ##1 s_access |=> pready;
	endproperty
	a_apb_ack: assert property (p_apb_ack) else $error("APB answer not one wait state");

	property p_adc_on;
		ce && gate && flags.converter_done && enable.converter_done |=> core_irq;
	endproperty
	a_adc_on: assert property (p_adc_on) else $error("converter interrupt lost");

	property p_adc_off;
		ce && flags == 8'h40 && !enable.converter_done |=> !core_irq;
	endproperty
	a_adc_off: assert property (p_adc_off) else $error("converter mask ignored");

	property p_rx_on;
		ce && gate && flags.serial_rx && enable.serial_rx |=> core_irq;
	endproperty
	a_rx_on: assert property (p_rx_on) else $error("receive interrupt lost");

	property p_tx_off;
		ce && flags == 8'h10 && !enable.serial_tx |=> !core_irq;
	endproperty
	a_tx_off: assert property (p_tx_off) else $error("transmit mask ignored");

	property p_match_off;
		ce && flags == 8'h02 && !enable.period_match |=> !core_irq;
	endproperty
	a_match_off: assert property (p_match_off) else $error("match mask ignored");

	property p_other_on;
		ce && gate && ((flags & enable & PIB_OTHER_MASK) != 8'h00) |=> core_irq;
	endproperty
	a_other_on: assert property (p_other_on) else $error("other source lost");

	property p_flag_hold;
		ce && !wr |=> flags == ($past(flags) | $past(src_event));
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("flag bits disturbed");

	property p_flag_set;
		ce && src_event != 8'h00 ##1 1'b1 |-> (flags & $past(src_event)) == $past(src_event);
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("event not latched");

	property p_group_off;
		ce && !core.peripheral_group_irq_en |=> !core_irq;
	endproperty
	a_group_off: assert property (p_group_off) else $error("group enable ignored");

	property p_global_off;
		ce && !core.global_irq_en |=> !core_irq;
	endproperty
	a_global_off: assert property (p_global_off) else $error("global enable ignored");

	property p_irq_stat;
		ce && ((status & mask) != 8'h00) |=> irq;
	endproperty
	a_irq_stat: assert property (p_irq_stat) else $error("level interrupt missing");

endmodule

// file: tb/pib_bank_tb.sv
// Purpose: self-checking bench for the peripheral interrupt enable bank
// Assumes: APB answer waited on pready, events are one-cycle pulses
// Notes: ce held high throughout
`timescale 1ns/1ps
module pib_bank_tb;
	import pib_pkg::*;
	logic        clk;
	logic        sys_rst;
	logic        ce;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        core_irq;
	logic        irq;
	logic [31:0] rd;
	logic        err;
	pib_src_type src_event;
	int          fails;
	int          checked;
	logic [7:0]  regs [5] = '{PIB_OFF_ENABLE, PIB_OFF_FLAGS, PIB_OFF_CORE, PIB_OFF_STAT,
		PIB_OFF_MASK};

	pib_bank #(.ADDR_W(8)) dut (.clk(clk), .sys_rst(sys_rst), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .src_event(src_event),
		.core_irq(core_irq), .irq(irq));

	task automatic final_report;
		$display("comparisons %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(negedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50)
			fails++;
		rd  = prdata;
		err = pslverr;
		@(posedge clk);
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(name, exp, rd);
	endtask

	// Event lands at the second edge, outputs one edge later
	task automatic fire(input logic [7:0] ev);
		@(posedge clk);
		src_event <= ev;
		@(posedge clk);
		src_event <= 8'h00;
	endtask

	task automatic settle;
		repeat (2) @(posedge clk);
		#1;
	endtask

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	initial begin
		#(25 * 20000);
		fails++;
		final_report();
	end

	initial begin
		sys_rst = 1'b1; ce = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
		paddr = 8'h00; pwdata = 32'h0; src_event = 8'h00; fails = 0; checked = 0;
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		for (int r = 0; r < 5; r++)
			rdc("reset value", regs[r], 32'h0);
		apb(1'b0, 8'h40, 32'h0);
		chk("unmapped data", 32'h0, rd);
		chk("unmapped error", 32'h1, {31'h0, err});
		wr(8'h40, 32'hff);
		rdc("enable after unmapped write", PIB_OFF_ENABLE, 32'h0);
		wr(PIB_OFF_ENABLE, 32'hffffff5a);
		rdc("enable readback", PIB_OFF_ENABLE, 32'h5a);
		wr(PIB_OFF_CORE, 32'hffffffff);
		rdc("core control readback", PIB_OFF_CORE, 32'hc0);
		for (int i = 0; i < 8; i++) begin
			wr(PIB_OFF_FLAGS, 32'h0);
			wr(PIB_OFF_ENABLE, {24'h0, ~(8'h01 << i)});
			fire(8'h01 << i);
			settle();
			chk("masked source", 32'h0, {31'h0, core_irq});
			rdc("flag position", PIB_OFF_FLAGS, 32'h1 << i);
			wr(PIB_OFF_FLAGS, 32'h0);
			wr(PIB_OFF_ENABLE, 32'h1 << i);
			settle();
			chk("no stale event", 32'h0, {31'h0, core_irq});
			fire(8'h01 << i);
			settle();
			chk("enabled source", 32'h1, {31'h0, core_irq});
		end
		wr(PIB_OFF_CORE, 32'h80);
		settle();
		chk("group enable off", 32'h0, {31'h0, core_irq});
		wr(PIB_OFF_CORE, 32'h40);
		settle();
		chk("global enable off", 32'h0, {31'h0, core_irq});
		wr(PIB_OFF_CORE, 32'hc0);
		settle();
		chk("both enables on", 32'h1, {31'h0, core_irq});
		wr(PIB_OFF_CORE, 32'h0);
		wr(PIB_OFF_ENABLE, 32'h0);
		wr(PIB_OFF_FLAGS, 32'h0);
		fire(8'h24);
		rdc("flags with all enables off", PIB_OFF_FLAGS, 32'h24);
		rdc("status sticky", PIB_OFF_STAT, 32'hff);
		rdc("status cleared by read", PIB_OFF_STAT, 32'h0);
		wr(PIB_OFF_MASK, 32'h10);
		fire(8'h10);
		settle();
		chk("unmasked status irq", 32'h1, {31'h0, irq});
		rdc("status one event", PIB_OFF_STAT, 32'h10);
		settle();
		chk("irq after status read", 32'h0, {31'h0, irq});
		fire(8'h02);
		settle();
		chk("masked status irq", 32'h0, {31'h0, irq});
		rdc("status masked event", PIB_OFF_STAT, 32'h02);
		final_report();
	end
endmodule
